// file: rtl/epi_pkg.sv
package epi_pkg;

  // ==========================================================================
  // Bus widths and register map.
  // ==========================================================================
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  localparam int          PC_W           = 8;
  localparam logic [7:0]  OFS_SENSE      = 8'h00;
  localparam logic [7:0]  OFS_MASK       = 8'h04;
  localparam logic [7:0]  OFS_FLAGS      = 8'h08;
  localparam logic [7:0]  OFS_PC_MASK    = 8'h0C;
  localparam logic [7:0]  OFS_PIN_STATE  = 8'h10;
  localparam logic [7:0]  OFS_PC_STATE   = 8'h14;

  // ==========================================================================
  // Field positions.
  // ==========================================================================
  localparam int          SENSE0_LO      = 0;
  localparam int          SENSE0_HI      = 1;
  localparam int          SENSE1_LO      = 2;
  localparam int          SENSE1_HI      = 3;
  localparam int          BIT_IRQ1       = 7;
  localparam int          BIT_IRQ0       = 6;
  localparam int          BIT_PC         = 5;
  localparam int          PIN_BIT_IRQ0   = 0;
  localparam int          PIN_BIT_IRQ1   = 1;

  // ==========================================================================
  // Reset values and implemented-bit masks.
  // ==========================================================================
  localparam logic [7:0]  SENSE_RESET    = 8'h00;
  localparam logic [7:0]  MASK_RESET     = 8'h00;
  localparam logic [7:0]  FLAGS_RESET    = 8'h00;
  localparam logic [7:0]  PC_MASK_RESET  = 8'h00;
  localparam logic [7:0]  MASK_IMPL      = 8'hE0;
  localparam logic [7:0]  FLAGS_IMPL     = 8'hE0;

  // ==========================================================================
  // Timing.
  // ==========================================================================
  localparam int          SYNC_STAGES    = 2;

  // Order of the members matches the two-bit sense field encoding.
  typedef enum logic [1:0] {
    EPI_SENSE_LOW,
    EPI_SENSE_ANY,
    EPI_SENSE_FALL,
    EPI_SENSE_RISE
  } epi_sense_t;

endpackage

// file: rtl/epi_sync.sv
`timescale 1ns/10ps
`default_nettype none
module epi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Asynchronous inputs and their synchronised copy.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ==========================================================================
  // Two-stage synchroniser; the first stage feeds only the second.
  // ==========================================================================
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

// file: rtl/epi_sense_detect.sv
`timescale 1ns/10ps
`default_nettype none
module epi_sense_detect (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Synchronised pin and selected sense mode.
  input  wire logic              pin_sync,
  input  wire epi_pkg::epi_sense_t sense,
  // One-cycle trigger for the edge and change modes.
  output logic                   trig_pulse
);

  // ==========================================================================
  // Edge detection on the sampled pin.
  // ==========================================================================
  logic                          prev_reg;
  logic [epi_pkg::SYNC_STAGES:0] arm_reg;
  logic                          armed;
  logic                          rise;
  logic                          fall;

  // The synchroniser shows its reset zero for a few cycles after release, so
  // the detector stays blind until the history holds a real pin sample; a
  // pin that is already high at release must not look like a rising edge.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prev_reg <= 1'b0;
      arm_reg  <= '0;
    end else begin
      prev_reg <= pin_sync;
      arm_reg  <= {arm_reg[epi_pkg::SYNC_STAGES-1:0], 1'b1};
    end
  end

  assign armed = arm_reg[epi_pkg::SYNC_STAGES];
  assign rise  = armed & pin_sync & ~prev_reg;
  assign fall  = armed & ~pin_sync & prev_reg;

  always_comb begin
    unique case (sense)
      epi_pkg::EPI_SENSE_LOW:  trig_pulse = 1'b0;
      epi_pkg::EPI_SENSE_ANY:  trig_pulse = rise | fall;
      epi_pkg::EPI_SENSE_FALL: trig_pulse = fall;
      epi_pkg::EPI_SENSE_RISE: trig_pulse = rise;
    endcase
  end

endmodule
`default_nettype wire

// file: rtl/epi_ext_irq.sv
// Overview of operation
// - Pins trigger requests even when driven as outputs.
// - Any enabled pin-change input toggle raises request.
// - Pin-change wake detection works without the clock.
// - Irq1 sense bits 3:2 select level/any/fall/rise.
// - Irq0 sense bits 1:0 use the same encoding.
// - Low level requests continuously while pin low.
// - Edge and change detection run on the clock.
// - Low-level wake detection is asynchronous.
// - Vanished wake level wakes but requests nothing.
// - Pin sampled first; longer pulses always detected.
// - Irq1 enable bit 7 gated by global enable.
// - Irq0 enable bit 6 gated by global enable.
// - Pin-change enable bit 5 gated by global enable.
// - Flag bit 7 sets on irq1 trigger, clears.
// - Flag bit 6 sets on irq0 trigger, clears.
// - Flag held clear while in low-level mode.
// - Flag bit 5 sets on masked pin change.
// - Pin-change mask bits enable individual pins.
// - Set flag plus enables requests the vector.
`timescale 1ns/10ps
`default_nettype none
module epi_ext_irq (
  // Clock and reset.
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // Register port.
  input  wire logic [epi_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [epi_pkg::DATA_W-1:0]  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [epi_pkg::DATA_W-1:0]  reg_rdata,
  // External pins, read back from the pad whatever its direction.
  input  wire logic                        ext_irq0_line,
  input  wire logic                        ext_irq1_line,
  input  wire logic [epi_pkg::PC_W-1:0]    pin_change_group_low,
  // CPU side.
  input  wire logic                        global_irq_enable,
  input  wire logic                        irq0_vector_taken,
  input  wire logic                        irq1_vector_taken,
  input  wire logic                        pin_change_vector_taken,
  output logic                             irq0_request,
  output logic                             irq1_request,
  output logic                             pin_change_request_a,
  // Asynchronous wake-up toward the sleep controller.
  output logic                             wake_request
);

  // ==========================================================================
  // Register address decode.
  // ==========================================================================
  function automatic logic addr_hit(input logic [epi_pkg::ADDR_W-1:0] addr,
                                    input logic [epi_pkg::ADDR_W-1:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  logic wr_sense;
  logic wr_mask;
  logic wr_flags;
  logic wr_pc_mask;

  assign wr_sense   = reg_wr & addr_hit(reg_addr, epi_pkg::OFS_SENSE);
  assign wr_mask    = reg_wr & addr_hit(reg_addr, epi_pkg::OFS_MASK);
  assign wr_flags   = reg_wr & addr_hit(reg_addr, epi_pkg::OFS_FLAGS);
  assign wr_pc_mask = reg_wr & addr_hit(reg_addr, epi_pkg::OFS_PC_MASK);

  // ==========================================================================
  // Software registers.
  // ==========================================================================
  logic [7:0] mcu_control_sense_reg;
  logic [7:0] general_irq_mask_reg;
  logic [7:0] pin_change_mask_reg;

  // Bits above the sense fields are stored for the rest of the chip.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mcu_control_sense_reg <= epi_pkg::SENSE_RESET;
    end else if (wr_sense) begin
      mcu_control_sense_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      general_irq_mask_reg <= epi_pkg::MASK_RESET;
    end else if (wr_mask) begin
      general_irq_mask_reg <= reg_wdata & epi_pkg::MASK_IMPL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_change_mask_reg <= epi_pkg::PC_MASK_RESET;
    end else if (wr_pc_mask) begin
      pin_change_mask_reg <= reg_wdata;
    end
  end

  // ==========================================================================
  // Sense mode decode.
  // ==========================================================================
  epi_pkg::epi_sense_t sense0;
  epi_pkg::epi_sense_t sense1;
  logic                level0_mode;
  logic                level1_mode;
  logic                en_irq0;
  logic                en_irq1;
  logic                en_pc;

  assign sense0 = epi_pkg::epi_sense_t'({mcu_control_sense_reg[epi_pkg::SENSE0_HI],
                                         mcu_control_sense_reg[epi_pkg::SENSE0_LO]});
  assign sense1 = epi_pkg::epi_sense_t'({mcu_control_sense_reg[epi_pkg::SENSE1_HI],
                                         mcu_control_sense_reg[epi_pkg::SENSE1_LO]});
  assign level0_mode = (sense0 == epi_pkg::EPI_SENSE_LOW);
  assign level1_mode = (sense1 == epi_pkg::EPI_SENSE_LOW);
  assign en_irq0 = general_irq_mask_reg[epi_pkg::BIT_IRQ0];
  assign en_irq1 = general_irq_mask_reg[epi_pkg::BIT_IRQ1];
  assign en_pc   = general_irq_mask_reg[epi_pkg::BIT_PC];

  // ==========================================================================
  // Pin sampling.
  // ==========================================================================
  // The pad level is used as is, so software driving the pin as an output
  // can raise its own interrupt.
  logic [1:0]              ext_sync;
  logic [epi_pkg::PC_W-1:0] pc_sync;

  epi_sync #(
    .WIDTH    (2)
  ) u_ext_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({ext_irq1_line, ext_irq0_line}),
    .sync_out (ext_sync)
  );

  epi_sync #(
    .WIDTH    (epi_pkg::PC_W)
  ) u_pc_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in (pin_change_group_low),
    .sync_out (pc_sync)
  );

  // ==========================================================================
  // Edge and change detection on the clock.
  // ==========================================================================
  logic trig0;
  logic trig1;

  epi_sense_detect u_det0 (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .pin_sync   (ext_sync[0]),
    .sense      (sense0),
    .trig_pulse (trig0)
  );

  epi_sense_detect u_det1 (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .pin_sync   (ext_sync[1]),
    .sense      (sense1),
    .trig_pulse (trig1)
  );

  // ==========================================================================
  // Pin-change detection.
  // ==========================================================================
  logic [epi_pkg::PC_W-1:0]      pc_prev_reg;
  logic [epi_pkg::SYNC_STAGES:0] pc_arm_reg;
  logic                          pc_armed;
  logic [epi_pkg::PC_W-1:0]      pc_toggled;
  logic                          pc_trig;

  // Blind until the history holds real pin samples, so pins that are high
  // at release do not count as a change.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pc_prev_reg <= '0;
      pc_arm_reg  <= '0;
    end else begin
      pc_prev_reg <= pc_sync;
      pc_arm_reg  <= {pc_arm_reg[epi_pkg::SYNC_STAGES-1:0], 1'b1};
    end
  end

  assign pc_armed = pc_arm_reg[epi_pkg::SYNC_STAGES];

  genvar gi;
  generate
    for (gi = 0; gi < epi_pkg::PC_W; gi++) begin : g_pc
      assign pc_toggled[gi] = pc_armed & (pc_sync[gi] ^ pc_prev_reg[gi])
                              & pin_change_mask_reg[gi];
    end
  endgenerate

  assign pc_trig = |pc_toggled;

  // ==========================================================================
  // Flags.
  // ==========================================================================
  // A trigger in the cycle of a clear keeps the flag, so no event is lost.
  logic [7:0] external_irq_flags_reg;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] flag_hold_clear;

  always_comb begin
    flag_set                       = 8'h00;
    flag_set[epi_pkg::BIT_IRQ1]    = trig1;
    flag_set[epi_pkg::BIT_IRQ0]    = trig0;
    flag_set[epi_pkg::BIT_PC]      = pc_trig;
    flag_clr                       = wr_flags ? reg_wdata : 8'h00;
    flag_clr[epi_pkg::BIT_IRQ1]    = flag_clr[epi_pkg::BIT_IRQ1] | irq1_vector_taken;
    flag_clr[epi_pkg::BIT_IRQ0]    = flag_clr[epi_pkg::BIT_IRQ0] | irq0_vector_taken;
    flag_clr[epi_pkg::BIT_PC]      = flag_clr[epi_pkg::BIT_PC] | pin_change_vector_taken;
    flag_hold_clear                = 8'h00;
    flag_hold_clear[epi_pkg::BIT_IRQ1] = level1_mode;
    flag_hold_clear[epi_pkg::BIT_IRQ0] = level0_mode;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      external_irq_flags_reg <= epi_pkg::FLAGS_RESET;
    end else begin
      external_irq_flags_reg <= ((external_irq_flags_reg & ~flag_clr) | flag_set)
                                & ~flag_hold_clear & epi_pkg::FLAGS_IMPL;
    end
  end

  // ==========================================================================
  // Requests toward the CPU.
  // ==========================================================================
  // In low-level mode the request follows the sampled pin and nothing is
  // latched: a level that is gone before the core looks produces nothing.
  logic level0_active;
  logic level1_active;

  assign level0_active = level0_mode & ~ext_sync[0];
  assign level1_active = level1_mode & ~ext_sync[1];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq0_request         <= 1'b0;
      irq1_request         <= 1'b0;
      pin_change_request_a <= 1'b0;
    end else begin
      irq0_request         <= global_irq_enable & en_irq0
                              & (level0_active
                                 | external_irq_flags_reg[epi_pkg::BIT_IRQ0]);
      irq1_request         <= global_irq_enable & en_irq1
                              & (level1_active
                                 | external_irq_flags_reg[epi_pkg::BIT_IRQ1]);
      pin_change_request_a <= global_irq_enable & en_pc
                              & external_irq_flags_reg[epi_pkg::BIT_PC];
    end
  end

  // ==========================================================================
  // Asynchronous wake-up.
  // ==========================================================================
  // This path reads the raw pads on purpose: with the clock stopped it is
  // the only thing that can notice activity. It is meant for the sleep
  // controller only and may glitch; nothing in this block samples it.
  logic [epi_pkg::PC_W-1:0] pc_raw_diff;

  assign pc_raw_diff  = (pin_change_group_low ^ pc_prev_reg) & pin_change_mask_reg;
  assign wake_request = (en_pc & (|pc_raw_diff))
                        | (en_irq0 & level0_mode & ~ext_irq0_line)
                        | (en_irq1 & level1_mode & ~ext_irq1_line);

  // ==========================================================================
  // Read-back.
  // ==========================================================================
  logic [7:0] rd_value;
  logic [7:0] pin_state;

  always_comb begin
    pin_state                        = 8'h00;
    pin_state[epi_pkg::PIN_BIT_IRQ0] = ext_sync[0];
    pin_state[epi_pkg::PIN_BIT_IRQ1] = ext_sync[1];
    rd_value                         = 8'h00;
    if (addr_hit(reg_addr, epi_pkg::OFS_SENSE)) begin
      rd_value = mcu_control_sense_reg;
    end else if (addr_hit(reg_addr, epi_pkg::OFS_MASK)) begin
      rd_value = general_irq_mask_reg;
    end else if (addr_hit(reg_addr, epi_pkg::OFS_FLAGS)) begin
      rd_value = external_irq_flags_reg;
    end else if (addr_hit(reg_addr, epi_pkg::OFS_PC_MASK)) begin
      rd_value = pin_change_mask_reg;
    end else if (addr_hit(reg_addr, epi_pkg::OFS_PIN_STATE)) begin
      rd_value = pin_state;
    end else if (addr_hit(reg_addr, epi_pkg::OFS_PC_STATE)) begin
      rd_value = pc_sync;
    end
  end

  // Read data stand in the cycle after each cycle of reg_rd and are zero otherwise.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_value : 8'h00;
    end
  end

endmodule
`default_nettype wire

// file: test/epi_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Pad model for the interrupt pins.
// A pad driven by the device's own port reads back the driven value, so
// software can make pin activity that the detectors see like any other.
module epi_pin_model (
  // External sources and the device's own port drive.
  input  wire logic [9:0] src,
  input  wire logic [9:0] drv_en,
  input  wire logic [9:0] drv_val,
  // Pad levels seen by the interrupt logic.
  output logic            ext_irq0_line,
  output logic            ext_irq1_line,
  output logic [7:0]      pin_change_group_low
);
  logic [9:0] pad;
  assign pad = (drv_en & drv_val) | (~drv_en & src);
  assign ext_irq0_line = pad[0];
  assign ext_irq1_line = pad[1];
  assign pin_change_group_low = pad[9:2];
endmodule
`default_nettype wire

// file: test/epi_ext_irq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checker for the external interrupt block.
module epi_ext_irq_asserts (
  // Clock and reset.
  input wire logic       clk_sys,
  input wire logic       rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Pins and CPU side.
  input wire logic       ext_irq0_line,
  input wire logic       ext_irq1_line,
  input wire logic [7:0] pin_change_group_low,
  input wire logic       global_irq_enable,
  input wire logic       irq0_request,
  input wire logic       irq1_request,
  input wire logic       pin_change_request_a
);
  // Control registers are rebuilt from the writes, since only ports are seen.
  logic [7:0] sense_sh;
  logic [7:0] mask_sh;
  logic [7:0] pcm_sh;
  logic       lo0;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_sh <= 8'h00;
      mask_sh  <= 8'h00;
      pcm_sh   <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == epi_pkg::OFS_SENSE) sense_sh <= reg_wdata;
      if (reg_addr == epi_pkg::OFS_MASK) mask_sh <= reg_wdata;
      if (reg_addr == epi_pkg::OFS_PC_MASK) pcm_sh <= reg_wdata;
    end
  end
  assign lo0 = sense_sh[1:0] == 2'h0;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  irq1_gate_a: assert property (irq1_request |-> $past(global_irq_enable))
    else $error("irq1 request without global enable");
  irq0_gate_a: assert property (irq0_request |-> $past(global_irq_enable))
    else $error("irq0 request without global enable");
  pc_gate_a: assert property (pin_change_request_a |-> $past(global_irq_enable))
    else $error("pin change request without global enable");
  fall0_seen_a: assert property ($fell(ext_irq0_line) && sense_sh[1:0] == 2'h2
    && mask_sh[6] && global_irq_enable |-> ##[3:6] irq0_request)
    else $error("falling edge on pin 0 not requested");
  rise1_seen_a: assert property ($rose(ext_irq1_line) && sense_sh[3:2] == 2'h3
    && mask_sh[7] && global_irq_enable |-> ##[3:6] irq1_request)
    else $error("rising edge on pin 1 not requested");
  level_hold_a: assert property ((lo0 && mask_sh[6] && global_irq_enable
    && !ext_irq0_line)[*5] |-> irq0_request)
    else $error("low level on pin 0 not requested");
  level_drop_a: assert property ((lo0 && ext_irq0_line)[*5] |-> !irq0_request)
    else $error("level request stays after pin high");
  level_flag_a: assert property ($past(reg_rd) && $past(lo0, 2)
    && $past(reg_addr) == epi_pkg::OFS_FLAGS |-> !reg_rdata[6])
    else $error("flag set in low level mode");
  pc_toggle_a: assert property ((((pin_change_group_low ^ $past(pin_change_group_low))
    & pcm_sh) != 8'h00) && mask_sh[5] && global_irq_enable
    |-> ##[3:6] pin_change_request_a)
    else $error("masked pin change not requested");
endmodule
bind epi_ext_irq epi_ext_irq_asserts epi_ext_irq_asserts_i (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .ext_irq0_line(ext_irq0_line), .ext_irq1_line(ext_irq1_line),
  .pin_change_group_low(pin_change_group_low), .global_irq_enable(global_irq_enable),
  .irq0_request(irq0_request), .irq1_request(irq1_request),
  .pin_change_request_a(pin_change_request_a)
);
`default_nettype wire

// file: test/test_epi_ext_irq.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Self-checking bench for the external interrupt block.
module test_epi_ext_irq;
  logic       clk_sys, rst, reg_wr, reg_rd, gie, tk0, tk1, tkp;
  logic       l0, l1, rq0, rq1, rqp, wake;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pc_pad;
  logic [9:0] src, drv_en, drv_val;
  int         error_cnt = 0;
  int         checks = 0;
  int         seed = 19;
  int         cyc = 0;
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  epi_pin_model epi_pin_model_i (.src(src), .drv_en(drv_en), .drv_val(drv_val),
    .ext_irq0_line(l0), .ext_irq1_line(l1), .pin_change_group_low(pc_pad));
  epi_ext_irq epi_ext_irq_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq0_line(l0), .ext_irq1_line(l1), .pin_change_group_low(pc_pad),
    .global_irq_enable(gie), .irq0_vector_taken(tk0), .irq1_vector_taken(tk1),
    .pin_change_vector_taken(tkp), .irq0_request(rq0), .irq1_request(rq1),
    .pin_change_request_a(rqp), .wake_request(wake));
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Clears all flags either by a write of ones or by the vector-entry pulses.
  task automatic clr(input logic by_write);
    if (by_write) begin
      wr(epi_pkg::OFS_FLAGS, 8'hE0);
    end else begin
      @(posedge clk_sys);
      {tk0, tk1, tkp} <= 3'h7;
      @(posedge clk_sys);
      {tk0, tk1, tkp} <= 3'h0;
    end
    rc(epi_pkg::OFS_FLAGS, 8'h00);
  endtask
  function automatic logic trig(input logic [1:0] m, input logic o, input logic n);
    case (m)
      2'h1: return o != n;
      2'h2: return o & ~n;
      2'h3: return ~o & n;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    logic [31:0] r;
    logic [7:0]  v, ms, pm, ev, pold;
    logic [1:0]  f;
    logic [9:0]  old;
    {rst, reg_wr, reg_rd, gie, tk0, tk1, tkp} = 7'h40;
    {reg_addr, reg_wdata} = 16'h0000;
    {src, drv_en, drv_val} = 30'h00000000;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rc(epi_pkg::OFS_SENSE, epi_pkg::SENSE_RESET);
    rc(epi_pkg::OFS_MASK, epi_pkg::MASK_RESET);
    rc(epi_pkg::OFS_FLAGS, epi_pkg::FLAGS_RESET);
    rc(epi_pkg::OFS_PC_MASK, epi_pkg::PC_MASK_RESET);
    rc(8'h20, 8'h00);
    wr(epi_pkg::OFS_MASK, 8'hFF);
    rc(epi_pkg::OFS_MASK, 8'hE0);
    // Odd passes force both pins to toggle with both pin enables and the global enable set.
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      v = {r[7:4], k[3:2], k[3:2]};
      ms = {r[9:8] | {2{k[0]}}, r[12], 5'h00};
      wr(epi_pkg::OFS_SENSE, v);
      rc(epi_pkg::OFS_SENSE, v);
      wr(epi_pkg::OFS_MASK, ms);
      gie <= r[10] | k[0];
      old = src;
      @(posedge clk_sys);
      src[1:0] <= src[1:0] ^ (r[1:0] | {2{k[0]}});
      repeat (8) @(posedge clk_sys);
      f = {trig(v[3:2], old[1], src[1]), trig(v[1:0], old[0], src[0])};
      rc(epi_pkg::OFS_FLAGS, {f, 6'h00});
      rc(epi_pkg::OFS_PIN_STATE, {6'h00, src[1:0]});
      if (v[1:0] == 2'h0) begin
        chk(rq0, ms[6] & gie & ~src[0]);
        chk(rq1, ms[7] & gie & ~src[1]);
        if (ms[6] && !src[0]) chk(wake, 1'b1);
      end else begin
        chk(rq0, f[0] & ms[6] & gie);
        chk(rq1, f[1] & ms[7] & gie);
      end
      clr(r[11]);
    end
    wr(epi_pkg::OFS_SENSE, 8'h05);
    for (int d = 0; d < 4; d++) begin
      @(posedge clk_sys);
      src[0] <= ~src[0];
      repeat (d) @(posedge clk_sys);
      wr(epi_pkg::OFS_FLAGS, 8'h40);
      repeat (8) @(posedge clk_sys);
      rc(epi_pkg::OFS_FLAGS, (d <= 1) ? 8'h40 : 8'h00);
      clr(1'b1);
    end
    for (int k = 0; k < 10; k++) begin
      r = $random(seed);
      pm = (k == 0) ? 8'h00 : ((k == 1) ? 8'hFF : r[7:0]);
      wr(epi_pkg::OFS_PC_MASK, pm);
      rc(epi_pkg::OFS_PC_MASK, pm);
      wr(epi_pkg::OFS_MASK, {2'h0, r[8] | k[0], 5'h00});
      gie <= r[9] | k[0];
      @(posedge clk_sys);
      pold = pc_pad;
      v = (r[23:16] & r[15:8]) | (~r[23:16] & r[31:24]);
      ev = (v ^ pold) & pm;
      src[9:2] <= r[31:24];
      drv_en[9:2] <= r[23:16];
      drv_val[9:2] <= r[15:8];
      #1 chk(wake, (|ev) & (r[8] | k[0]));
      repeat (8) @(posedge clk_sys);
      rc(epi_pkg::OFS_FLAGS, {2'h0, |ev, 5'h00});
      rc(epi_pkg::OFS_PC_STATE, v);
      chk(rqp, (|ev) & (r[8] | k[0]) & gie);
      clr(r[10]);
    end
    // Reset with both pins high: the sampled history must not fake an edge.
    @(posedge clk_sys);
    src[1:0] <= 2'h3;
    rst      <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    wr(epi_pkg::OFS_SENSE, 8'h0F);
    repeat (8) @(posedge clk_sys);
    rc(epi_pkg::OFS_FLAGS, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
